// file: hw/goc_regs.sv
// Implementation choice: the APB interface to the registers.
`timescale 1ns/1ps
// What this block does
// - Soft sync bit starts output resynchronization
// - Stall outputs while set, restart on fall
// - Buffered bits apply only on update strobe
// - Applied rising calibrate bit calibrates system clock
// - Applied rising calibrate-all calibrates every PLL
// - Calibrate-all never clears itself; software clears
// - Calibrate-all set masks per-PLL calibration requests
// - Power-down bit puts device in sleep
// - Reference receiver power-down bits, default powered
// - Timeout bit forces unfaulted reference valid
// - Timeout bits clear themselves, reset to zero
// - Forced-fault reference ignores timeout writes
module goc_regs #(
	parameter int ADDR_W = 14
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [ADDR_W-1:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic [goc_pkg::NUM_APLLS-1:0] apll_cal_req,
	output goc_pkg::goc_ctl_out_t ctl
);
	import goc_pkg::*;

	goc_regs_t s;
	goc_regs_t next_s;
	goc_cal_t cal;
	logic [NUM_REFS-1:0] ref_force;
	logic [NUM_REFS-1:0] timeout_wr;
	logic [ADDR_W-3:0] idx;
	logic aligned;
	logic hit_upd;
	logic hit_ctrl;
	logic hit_pd;
	logic hit_to;
	logic hit_fault;
	logic hit_stat;
	logic mapped;
	logic setup_ph;
	logic access_wr;
	logic upd_wr;

	// Address decode, one word per register
	assign idx = paddr[ADDR_W-1:2];
	assign aligned = (paddr[1:0] == 2'h0);
	assign hit_upd = aligned && (idx == (ADDR_W-2)'(IDX_UPDATE));
	assign hit_ctrl = aligned && (idx == (ADDR_W-2)'(IDX_CTRL));
	assign hit_pd = aligned && (idx == (ADDR_W-2)'(IDX_REF_PD));
	assign hit_to = aligned && (idx == (ADDR_W-2)'(IDX_REF_TIMEOUT));
	assign hit_fault = aligned && (idx == (ADDR_W-2)'(IDX_REF_FAULT));
	assign hit_stat = aligned && (idx == (ADDR_W-2)'(IDX_STATUS));
	assign mapped = hit_upd | hit_ctrl | hit_pd | hit_to | hit_fault
		| hit_stat;

	// Bus phases; writes land at the end of the access phase
	assign setup_ph = psel & ~penable;
	assign access_wr = psel & penable & pwrite & mapped;

	// Only the exact strobe value applies buffered bits
	assign upd_wr = access_wr & hit_upd
		& (pwdata[7:0] == UPDATE_VALUE);

	// Timeout writes go straight to the force stage
	assign timeout_wr = (access_wr & hit_to) ?
		pwdata[NUM_REFS-1:0] : '0;

	// Register update and read capture
	always_comb begin
		next_s = s;
		next_s.update = upd_wr;
		next_s.sync_restart = 1'b0;
		if (access_wr && hit_ctrl) begin
			next_s.ctrl = pwdata[3:0];
		end
		if (access_wr && hit_pd) begin
			next_s.ref_pd = pwdata[NUM_REFS-1:0];
		end
		if (access_wr && hit_fault) begin
			next_s.ref_fault = pwdata[NUM_REFS-1:0];
		end
		// Applied soft sync and its falling edge
		if (s.update) begin
			next_s.sync_active = s.ctrl[CTRL_SOFT_SYNC_BIT];
			next_s.sync_restart = s.sync_active
				& ~s.ctrl[CTRL_SOFT_SYNC_BIT];
		end
		// Read data and error captured in the setup phase
		if (setup_ph) begin
			next_s.slverr = ~mapped;
			next_s.prdata = 32'h0000_0000;
			if (!pwrite) begin
				if (hit_ctrl) begin
					next_s.prdata[3:0] = s.ctrl;
				end else if (hit_pd) begin
					next_s.prdata[NUM_REFS-1:0] = s.ref_pd;
				end else if (hit_fault) begin
					next_s.prdata[NUM_REFS-1:0] = s.ref_fault;
				end else if (hit_stat) begin
					next_s.prdata[STAT_SYNC_BIT] = s.sync_active;
					next_s.prdata[STAT_CAL_SYSTEM_CLOCK_BIT] =
						cal.system_clock_active;
					next_s.prdata[STAT_CAL_ALL_BIT] = cal.all_active;
				end
			end
		end
	end

	// State register
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s <= '0;
			s.ctrl <= CTRL_RESET;
			s.ref_pd <= REF_PD_RESET;
			s.ref_fault <= REF_FAULT_RESET;
		end else begin
			s <= next_s;
		end
	end

	// Calibration launch from the applied buffered bits
	goc_cal_trigger u_cal (
		.pclk(pclk),
		.presetn(presetn),
		.update(s.update),
		.shadow_system_clock(s.ctrl[CTRL_CAL_SYSTEM_CLOCK_BIT]),
		.shadow_all(s.ctrl[CTRL_CAL_ALL_BIT]),
		.apll_cal_req(apll_cal_req),
		.cal(cal)
	);

	// Validation timer force pulses
	goc_ref_force u_force (
		.pclk(pclk),
		.presetn(presetn),
		.timeout_wr(timeout_wr),
		.ref_fault(s.ref_fault),
		.ref_timer_force(ref_force)
	);

	// Bus answers: one wait-free access phase after setup
	assign pready = psel & penable;
	assign prdata = s.prdata;
	assign pslverr = s.slverr & psel & penable;

	// Control outputs, all from flip-flops
	always_comb begin
		ctl.deep_sleep = s.ctrl[CTRL_POWER_DOWN_BIT];
		ctl.ref_rx_power_down = s.ref_pd;
		ctl.sync_stall = s.sync_active;
		ctl.sync_restart = s.sync_restart;
		ctl.system_clock_cal_start = cal.system_clock_start;
		ctl.apll_cal_start = cal.apll_start;
		ctl.ref_timer_force = ref_force;
	end

	a_sync_applied: assert property (
		@(posedge pclk) disable iff (!presetn)
		s.update |=> ctl.sync_stall == $past(s.ctrl[CTRL_SOFT_SYNC_BIT]))
		else $error("soft sync not applied at update");

	a_sync_buffered: assert property (
		@(posedge pclk) disable iff (!presetn)
		!s.update |=> $stable(ctl.sync_stall) && $stable(cal.all_active))
		else $error("buffered bit changed without update");

	a_sync_restart: assert property (
		@(posedge pclk) disable iff (!presetn)
		s.update && s.sync_active && !s.ctrl[CTRL_SOFT_SYNC_BIT]
		|=> ctl.sync_restart ##1 !ctl.sync_restart)
		else $error("restart pulse missing after soft sync fall");

	a_update_path: assert property (
		@(posedge pclk) disable iff (!presetn)
		psel && penable && pwrite && hit_upd && pwdata[7:0] != UPDATE_VALUE
		|=> !s.update)
		else $error("update taken with wrong strobe value");

	a_system_clock_cal: assert property (
		@(posedge pclk) disable iff (!presetn)
		s.update && s.ctrl[CTRL_CAL_SYSTEM_CLOCK_BIT] && !cal.system_clock_active
		|=> ctl.system_clock_cal_start)
		else $error("system clock calibration not started");

	a_cal_all: assert property (
		@(posedge pclk) disable iff (!presetn)
		s.update && s.ctrl[CTRL_CAL_ALL_BIT] && !cal.all_active
		|=> ctl.system_clock_cal_start && ctl.apll_cal_start == '1)
		else $error("calibrate all did not start every PLL");

	a_cal_all_kept: assert property (
		@(posedge pclk) disable iff (!presetn)
		cal.all_active && !s.update |=> cal.all_active)
		else $error("calibrate all cleared by itself");

	a_cal_single: assert property (
		@(posedge pclk) disable iff (!presetn)
		ctl.system_clock_cal_start |=> !ctl.system_clock_cal_start)
		else $error("calibration started twice for one edge");

	a_deep_sleep: assert property (
		@(posedge pclk) disable iff (!presetn)
		psel && penable && pwrite && hit_ctrl
		|=> ctl.deep_sleep == $past(pwdata[CTRL_POWER_DOWN_BIT]))
		else $error("deep sleep does not follow the write");

	a_ref_pd_write: assert property (
		@(posedge pclk) disable iff (!presetn)
		psel && penable && pwrite && hit_pd
		|=> ctl.ref_rx_power_down == $past(pwdata[NUM_REFS-1:0]))
		else $error("receiver power-down does not follow the write");

	a_timeout_reads0: assert property (
		@(posedge pclk) disable iff (!presetn)
		setup_ph && !pwrite && hit_to |=> prdata == 32'h0000_0000)
		else $error("timeout register did not read as zero");

	// Soft sync pulse and applied calibrate bits
	a_no_restart_high: assert property (
		@(posedge pclk) disable iff (!presetn)
		s.update && s.ctrl[CTRL_SOFT_SYNC_BIT]
		|=> !ctl.sync_restart)
		else $error("restart pulse while soft sync stays set");

	a_restart_upd_only: assert property (
		@(posedge pclk) disable iff (!presetn)
		!s.update
		|=> !ctl.sync_restart)
		else $error("restart pulse without an update");

	a_no_cal_low: assert property (
		@(posedge pclk) disable iff (!presetn)
		s.update && !s.ctrl[CTRL_CAL_SYSTEM_CLOCK_BIT] && !s.ctrl[CTRL_CAL_ALL_BIT]
		|=> !ctl.system_clock_cal_start)
		else $error("calibration started with both bits low");

	a_no_cal_unchanged: assert property (
		@(posedge pclk) disable iff (!presetn)
		s.update && cal.system_clock_active == s.ctrl[CTRL_CAL_SYSTEM_CLOCK_BIT]
		&& cal.all_active == s.ctrl[CTRL_CAL_ALL_BIT]
		|=> !ctl.system_clock_cal_start)
		else $error("calibration started without a rising bit");

	a_apll_follows_req: assert property (
		@(posedge pclk) disable iff (!presetn)
		!cal.all_active && !(s.update && s.ctrl[CTRL_CAL_ALL_BIT])
		|=> ctl.apll_cal_start == $past(apll_cal_req))
		else $error("per-PLL request lost while not masked");

	a_all_applied: assert property (
		@(posedge pclk) disable iff (!presetn)
		s.update
		|=> cal.all_active == $past(s.ctrl[CTRL_CAL_ALL_BIT]))
		else $error("calibrate all not applied at update");

	a_system_clock_applied: assert property (
		@(posedge pclk) disable iff (!presetn)
		s.update
		|=> cal.system_clock_active == $past(s.ctrl[CTRL_CAL_SYSTEM_CLOCK_BIT]))
		else $error("system clock calibrate bit not applied");

	a_system_clock_buffered: assert property (
		@(posedge pclk) disable iff (!presetn)
		!s.update
		|=> $stable(cal.system_clock_active))
		else $error("system clock bit applied without update");

	a_update_strobe_only: assert property (
		@(posedge pclk) disable iff (!presetn)
		!(psel && penable && pwrite && hit_upd)
		|=> !s.update)
		else $error("update raised without a strobe write");

	// Live registers, written only by the bus
	a_ctrl_write: assert property (
		@(posedge pclk) disable iff (!presetn)
		psel && penable && pwrite && hit_ctrl
		|=> s.ctrl == $past(pwdata[3:0]))
		else $error("control register did not take the write");

	a_ctrl_kept: assert property (
		@(posedge pclk) disable iff (!presetn)
		!(psel && penable && pwrite && hit_ctrl)
		|=> $stable(s.ctrl))
		else $error("control register changed by itself");

	a_sleep_kept: assert property (
		@(posedge pclk) disable iff (!presetn)
		!(psel && penable && pwrite && hit_ctrl)
		|=> $stable(ctl.deep_sleep))
		else $error("deep sleep changed without a write");

	a_pd_kept: assert property (
		@(posedge pclk) disable iff (!presetn)
		!(psel && penable && pwrite && hit_pd)
		|=> $stable(ctl.ref_rx_power_down))
		else $error("receiver power-down changed without a write");

	a_fault_write: assert property (
		@(posedge pclk) disable iff (!presetn)
		psel && penable && pwrite && hit_fault
		|=> s.ref_fault == $past(pwdata[NUM_REFS-1:0]))
		else $error("fault register did not take the write");

	a_fault_kept: assert property (
		@(posedge pclk) disable iff (!presetn)
		!(psel && penable && pwrite && hit_fault)
		|=> $stable(s.ref_fault))
		else $error("fault register changed by itself");

	a_force_path: assert property (
		@(posedge pclk) disable iff (!presetn)
		psel && penable && pwrite && hit_to
		|=> ctl.ref_timer_force
		== ($past(pwdata[NUM_REFS-1:0]) & ~$past(s.ref_fault)))
		else $error("timeout force does not match write and faults");

	a_force_idle: assert property (
		@(posedge pclk) disable iff (!presetn)
		!(psel && penable && pwrite && hit_to)
		|=> ctl.ref_timer_force == '0)
		else $error("timeout force without a write");

	// Read data captured in the setup phase
	a_ctrl_read: assert property (
		@(posedge pclk) disable iff (!presetn)
		setup_ph && !pwrite && hit_ctrl
		|=> prdata == {28'h0, $past(s.ctrl)})
		else $error("control register read back wrong");

	a_status_read: assert property (
		@(posedge pclk) disable iff (!presetn)
		setup_ph && !pwrite && hit_stat
		|=> prdata[STAT_SYNC_BIT] == $past(s.sync_active))
		else $error("status does not show the applied sync");

endmodule

// file: include/goc_pkg.sv
package goc_pkg;

	// Register indices; byte address is four times the index
	localparam logic [11:0] IDX_UPDATE = 12'h00f;
	localparam logic [11:0] IDX_CTRL = 12'ha00;
	localparam logic [11:0] IDX_REF_PD = 12'ha01;
	localparam logic [11:0] IDX_REF_TIMEOUT = 12'ha02;
	localparam logic [11:0] IDX_REF_FAULT = 12'ha03;
	localparam logic [11:0] IDX_STATUS = 12'haff;

	// Field positions of the global operation control register
	localparam int CTRL_POWER_DOWN_BIT = 0;
	localparam int CTRL_CAL_ALL_BIT = 1;
	localparam int CTRL_CAL_SYSTEM_CLOCK_BIT = 2;
	localparam int CTRL_SOFT_SYNC_BIT = 3;

	// Field positions of the status register
	localparam int STAT_SYNC_BIT = 0;
	localparam int STAT_CAL_SYSTEM_CLOCK_BIT = 1;
	localparam int STAT_CAL_ALL_BIT = 2;

	// Value that applies buffered bits when written to the update register
	localparam logic [7:0] UPDATE_VALUE = 8'h01;

	// Reset values
	localparam logic [3:0] CTRL_RESET = 4'h0;
	localparam logic [3:0] REF_PD_RESET = 4'h0;
	localparam logic [3:0] REF_FAULT_RESET = 4'h0;

	localparam int NUM_REFS = 4;
	localparam int NUM_APLLS = 4;

	// Control outputs toward the clock core
	typedef struct packed {
		logic deep_sleep;
		logic [NUM_REFS-1:0] ref_rx_power_down;
		logic sync_stall;
		logic sync_restart;
		logic system_clock_cal_start;
		logic [NUM_APLLS-1:0] apll_cal_start;
		logic [NUM_REFS-1:0] ref_timer_force;
	} goc_ctl_out_t;

	// State of the register bank
	typedef struct packed {
		logic [3:0] ctrl;
		logic [NUM_REFS-1:0] ref_pd;
		logic [NUM_REFS-1:0] ref_fault;
		logic sync_active;
		logic sync_restart;
		logic update;
		logic slverr;
		logic [31:0] prdata;
	} goc_regs_t;

	// State of the calibration trigger
	typedef struct packed {
		logic system_clock_active;
		logic all_active;
		logic system_clock_start;
		logic [NUM_APLLS-1:0] apll_start;
	} goc_cal_t;

endpackage

// file: hw/goc_ref_force.sv
`timescale 1ns/1ps
module goc_ref_force (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic [goc_pkg::NUM_REFS-1:0] timeout_wr,
	input wire logic [goc_pkg::NUM_REFS-1:0] ref_fault,
	output logic [goc_pkg::NUM_REFS-1:0] ref_timer_force
);
	import goc_pkg::*;

	logic [NUM_REFS-1:0] s;
	logic [NUM_REFS-1:0] next_s;
	logic [NUM_REFS-1:0] gated;

	// Forced-faulted references ignore the timeout write
	for (genvar i = 0; i < NUM_REFS; i++) begin : g_ref
		assign gated[i] = timeout_wr[i] & ~ref_fault[i];
	end

	// One-cycle force pulse, clears on its own
	always_comb begin
		next_s = gated;
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s <= '0;
		end else begin
			s <= next_s;
		end
	end

	assign ref_timer_force = s;

	for (genvar i = 0; i < NUM_REFS; i++) begin : g_chk
		a_force_taken: assert property (
			@(posedge pclk) disable iff (!presetn)
			timeout_wr[i] && !ref_fault[i] |=> ref_timer_force[i])
			else $error("timeout write did not force the timer");
		a_fault_blocks: assert property (
			@(posedge pclk) disable iff (!presetn)
			ref_fault[i] |=> !ref_timer_force[i])
			else $error("faulted reference was forced valid");
		a_force_clears: assert property (
			@(posedge pclk) disable iff (!presetn)
			!timeout_wr[i] |=> !ref_timer_force[i])
			else $error("timeout force did not clear itself");
	end

endmodule

// file: hw/goc_cal_trigger.sv
`timescale 1ns/1ps
module goc_cal_trigger (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic update,
	input wire logic shadow_system_clock,
	input wire logic shadow_all,
	input wire logic [goc_pkg::NUM_APLLS-1:0] apll_cal_req,
	output goc_pkg::goc_cal_t cal
);
	import goc_pkg::*;

	goc_cal_t s;
	goc_cal_t next_s;
	logic system_clock_edge;
	logic all_edge;

	// Rising edges of the applied bits, seen only at an update
	assign system_clock_edge = update & shadow_system_clock & ~s.system_clock_active;
	assign all_edge = update & shadow_all & ~s.all_active;

	// Apply buffered bits and launch calibration pulses
	always_comb begin
		next_s = s;
		if (update) begin
			next_s.system_clock_active = shadow_system_clock;
			next_s.all_active = shadow_all;
		end
		next_s.system_clock_start = system_clock_edge | all_edge;
		if (all_edge) begin
			next_s.apll_start = '1;
		end else if (s.all_active) begin
			next_s.apll_start = '0;
		end else begin
			next_s.apll_start = apll_cal_req;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s <= '0;
		end else begin
			s <= next_s;
		end
	end

	assign cal = s;

	a_apll_masked: assert property (
		@(posedge pclk) disable iff (!presetn)
		s.all_active && !all_edge |=> cal.apll_start == '0)
		else $error("per-PLL calibration not masked");
	a_one_start: assert property (
		@(posedge pclk) disable iff (!presetn)
		!update |=> !cal.system_clock_start)
		else $error("calibration started without an update");

endmodule

// file: sim/tb_top.sv
`timescale 1ns/1ps
module tb_top;
	import goc_pkg::*;
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [13:0] paddr = 14'h0000;
	logic [31:0] pwdata = 32'h00000000;
	logic [3:0] apll_cal_req = 4'h0;
	logic [31:0] prdata;
	logic pready;
	logic pslverr;
	goc_ctl_out_t ctl;
	int n_mismatch = 0;
	int check_count = 0;
	int cyc = 0;
	logic [31:0] seed = 32'h00000030;
	logic [31:0] rd;
	logic err;
	logic [31:0] sys_cnt = 32'h0;
	logic [31:0] rst_cnt = 32'h0;
	logic [31:0] ap_cnt [4] = '{default: 32'h0};
	logic [31:0] tf_cnt [4] = '{default: 32'h0};
	logic [31:0] base [4];
	logic [3:0] flt;
	logic [3:0] fexp;

	goc_regs #(.ADDR_W(14)) i_dut (.pclk(pclk), .presetn(presetn),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .apll_cal_req(apll_cal_req), .ctl(ctl));

	// Free running clock, 10 ns period
	initial begin
		forever #5 pclk = ~pclk;
	end

	// Pulse counters on the control outputs
	always @(posedge pclk) begin
		sys_cnt <= sys_cnt + 32'(ctl.system_clock_cal_start === 1'b1);
		rst_cnt <= rst_cnt + 32'(ctl.sync_restart === 1'b1);
		for (int i = 0; i < 4; i++) begin
			ap_cnt[i] <= ap_cnt[i] + 32'(ctl.apll_cal_start[i] === 1'b1);
			tf_cnt[i] <= tf_cnt[i] + 32'(ctl.ref_timer_force[i] === 1'b1);
		end
	end

	// Hang guard
	always @(posedge pclk) begin
		cyc <= cyc + 1;
		if (cyc == 5000) begin
			n_mismatch++;
			conclude();
		end
	end

	function automatic logic [31:0] xs(input logic [31:0] s);
		s = s ^ (s << 13);
		s = s ^ (s >> 17);
		s = s ^ (s << 5);
		return s;
	endfunction

	// Forced references are those written one and not faulted
	function automatic logic [3:0] exp_force(input logic [3:0] w,
		input logic [3:0] f);
		return w & ~f;
	endfunction

	task automatic chk(input string name, input logic [31:0] seen,
		input logic [31:0] exp);
		check_count++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("Error %s expected %h seen %h", name, exp, seen);
		end
	endtask

	// One APB transfer; waits for pready, samples at that edge
	task automatic apb(input logic w, input logic [11:0] idx,
		input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= {idx, 2'b00};
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1) @(posedge pclk);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic wait_settle(input int n);
		repeat (n) @(posedge pclk);
		#1;
	endtask

	task automatic conclude();
		$display("Checks %0d mismatches %0d", check_count, n_mismatch);
		if (n_mismatch == 0 && check_count > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask

	initial begin
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		// Reset values and an unmapped place
		wait_settle(1);
		chk("ctl", 32'(ctl), 32'h0);
		for (int i = 0; i < 4; i++) begin
			apb(1'b0, IDX_CTRL + 12'(i), 32'h0);
			chk("reset_rd", rd, 32'h0);
		end
		apb(1'b0, 12'h123, 32'h0);
		chk("unmapped_err", 32'(err), 32'h1);
		$display("Test reset done");
		// Live power-down bits
		for (int k = 0; k < 6; k++) begin
			seed = xs(seed);
			apb(1'b1, IDX_REF_PD, {28'h0, seed[3:0]});
			wait_settle(1);
			chk("ref_pd", 32'(ctl.ref_rx_power_down), 32'(seed[3:0]));
			apb(1'b1, IDX_CTRL, {31'h0, seed[4]});
			wait_settle(1);
			chk("sleep", 32'(ctl.deep_sleep), 32'(seed[4]));
		end
		apb(1'b1, IDX_CTRL, 32'h0);
		$display("Test power down done");
		// Soft sync buffered, bad strobe ignored, restart on fall
		apb(1'b1, IDX_CTRL, 32'h8);
		apb(1'b1, IDX_UPDATE, 32'h2);
		wait_settle(3);
		chk("stall_early", 32'(ctl.sync_stall), 32'h0);
		apb(1'b1, IDX_UPDATE, 32'(UPDATE_VALUE));
		wait_settle(3);
		chk("stall", 32'(ctl.sync_stall), 32'h1);
		chk("restart_none", rst_cnt, 32'h0);
		apb(1'b1, IDX_CTRL, 32'h0);
		wait_settle(3);
		chk("stall_held", 32'(ctl.sync_stall), 32'h1);
		apb(1'b1, IDX_UPDATE, 32'(UPDATE_VALUE));
		wait_settle(3);
		chk("stall_off", 32'(ctl.sync_stall), 32'h0);
		chk("restart", rst_cnt, 32'h1);
		$display("Test soft sync done");
		// System clock calibration, one per applied rising edge
		apb(1'b1, IDX_CTRL, 32'h4);
		wait_settle(3);
		chk("sys_early", sys_cnt, 32'h0);
		for (int k = 0; k < 3; k++) begin
			apb(1'b1, IDX_UPDATE, 32'(UPDATE_VALUE));
			wait_settle(3);
			chk("sys_once", sys_cnt, 32'h1);
		end
		apb(1'b1, IDX_CTRL, 32'h0);
		apb(1'b1, IDX_UPDATE, 32'(UPDATE_VALUE));
		wait_settle(3);
		chk("sys_fall", sys_cnt, 32'h1);
		$display("Test system_clock cal done");
		// Calibrate all, mask of per-PLL requests, no self clear
		apb(1'b1, IDX_CTRL, 32'h2);
		apb(1'b1, IDX_UPDATE, 32'(UPDATE_VALUE));
		wait_settle(3);
		chk("sys_all", sys_cnt, 32'h2);
		for (int i = 0; i < 4; i++) begin
			chk("apll_all", ap_cnt[i], 32'h1);
		end
		seed = xs(seed);
		@(posedge pclk);
		apll_cal_req <= seed[3:0] | 4'h1;
		repeat (5) @(posedge pclk);
		apll_cal_req <= 4'h0;
		wait_settle(3);
		for (int i = 0; i < 4; i++) begin
			chk("apll_mask", ap_cnt[i], 32'h1);
		end
		apb(1'b0, IDX_CTRL, 32'h0);
		chk("cal_all_kept", rd, 32'h2);
		apb(1'b1, IDX_STATUS, 32'h7);
		apb(1'b0, IDX_STATUS, 32'h0);
		chk("status", rd, 32'h1 << STAT_CAL_ALL_BIT);
		apb(1'b1, IDX_CTRL, 32'h0);
		apb(1'b1, IDX_UPDATE, 32'(UPDATE_VALUE));
		wait_settle(3);
		@(posedge pclk);
		apll_cal_req <= 4'h5;
		@(posedge pclk);
		apll_cal_req <= 4'h0;
		wait_settle(3);
		for (int i = 0; i < 4; i++) begin
			chk("apll_req", ap_cnt[i], 32'h1 + 32'(i % 2 == 0));
		end
		$display("Test cal all done");
		// Timeout bits gated by forced faults
		for (int k = 0; k < 6; k++) begin
			seed = xs(seed);
			flt = (k == 0) ? 4'hf : seed[3:0];
			for (int i = 0; i < 4; i++) base[i] = tf_cnt[i];
			apb(1'b1, IDX_REF_FAULT, {28'h0, flt});
			apb(1'b1, IDX_REF_TIMEOUT, {28'h0, seed[7:4] | 4'h1});
			apb(1'b0, IDX_REF_TIMEOUT, 32'h0);
			chk("timeout_rd", rd, 32'h0);
			wait_settle(2);
			fexp = exp_force(seed[7:4] | 4'h1, flt);
			for (int i = 0; i < 4; i++) begin
				chk("force", tf_cnt[i] - base[i], 32'(fexp[i]));
			end
			chk("force_low", 32'(ctl.ref_timer_force), 32'h0);
		end
		$display("Test timeout done");
		conclude();
	end
endmodule
